// ### src/sac_pkg.sv
/*
  Shared constants for the converter controller: register addresses, field positions,
  reset values and conversion-time counts.
  Assumes a byte-wide internal register port at the printed addresses and a 250 MHz clock.
*/
package sac_pkg;
  localparam logic [15:0] SAC_ADDR_RESULT_LO = 16'hFF08;
  localparam logic [15:0] SAC_ADDR_RESULT_HI = 16'hFF09;
  localparam logic [15:0] SAC_ADDR_MODE = 16'hFF28;
  localparam logic [15:0] SAC_ADDR_CHANNEL = 16'hFF29;
  localparam logic [15:0] SAC_ADDR_CMP_MODE = 16'hFF2A;
  localparam logic [15:0] SAC_ADDR_THRESHOLD = 16'hFF2B;
  localparam logic [7:0] SAC_RESET_BYTE = 8'h00;
  localparam int SAC_MODE_RUN_BIT = 7;
  localparam int SAC_MODE_REF_BIT = 0;
  localparam int SAC_MODE_TIME_LSB = 3;
  localparam int SAC_CMP_ENABLE_BIT = 7;
  localparam int SAC_CMP_POLARITY_BIT = 6;
  localparam logic [7:0] SAC_MODE_MASK = 8'hB9;
  localparam logic [7:0] SAC_CHANNEL_MASK = 8'h07;
  localparam logic [7:0] SAC_CMP_MASK = 8'hC0;
  localparam int SAC_RESULT_SHIFT = 6;
  localparam int SAC_BITS = 10;
  // Base clocks per conversion time; the controller runs at a clock rate of its own.
  localparam int SAC_CLK_MHZ = 250;
  localparam int SAC_REF_FX_MHZ = 10;
  localparam int SAC_SCALE = SAC_CLK_MHZ / SAC_REF_FX_MHZ;
  localparam logic [15:0] SAC_T288 = 16'(288 * SAC_SCALE);
  localparam logic [15:0] SAC_T240 = 16'(240 * SAC_SCALE);
  localparam logic [15:0] SAC_T192 = 16'(192 * SAC_SCALE);
  localparam logic [15:0] SAC_T144 = 16'(144 * SAC_SCALE);
  localparam logic [15:0] SAC_T120 = 16'(120 * SAC_SCALE);
  localparam logic [15:0] SAC_T96 = 16'(96 * SAC_SCALE);
  // Sampling takes twelve slots in every twenty-two; ten slots carry decisions.
  localparam logic [15:0] SAC_SLOTS = 16'h0016;
  localparam logic [15:0] SAC_SAMPLE_SLOTS = 16'h000C;
endpackage

// ### src/sac_slot_timer.sv
/*
  Slot timer: divides the selected conversion time into equal slots.
  Assumes restart is a one-cycle pulse from the controller on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sac_slot_timer
  import sac_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Control
  input wire logic restart,
  input wire logic [15:0] slot_len,
  // Status
  output logic slot_end
);
  typedef struct packed {
    logic [15:0] cnt;
  } sac_tmr_t;
  sac_tmr_t st_ff;
  sac_tmr_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (restart || st_ff.cnt == 16'h0000) begin
      nxt_st.cnt = slot_len - 16'h0001;
    end else begin
      nxt_st.cnt = st_ff.cnt - 16'h0001;
    end
  end

  // The controller lets a restart win over a slot end, so no path runs back through restart.
  assign slot_end = (st_ff.cnt == 16'h0000);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule
`default_nettype wire

// ### src/sac_sync2.sv
/*
  Two-stage synchroniser for the comparator decision.
  Assumes the input is asynchronous to clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sac_sync2
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Data
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic s1;
    logic s2;
  } sac_sync_t;
  sac_sync_t st_ff;
  sac_sync_t nxt_st;

  always_comb begin
    nxt_st.s1 = din;
    nxt_st.s2 = st_ff.s1;
  end

  assign dout = st_ff.s2;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule
`default_nettype wire

// ### src/sac_adc_ctrl.sv
/*
  Successive-approximation converter controller with threshold-gated done interrupt.
  Assumes a byte register port with one-cycle strobes and an analog front end that
  follows channel, hold and tap outputs and answers on cmp_in.
*/
`timescale 1ns/1ps
`default_nettype none
module sac_adc_ctrl
  import sac_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_rd16,
  input wire logic [7:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_wait,
  // Interrupt
  output logic conversion_done_irq,
  // Analog front end
  output logic [2:0] channel_sel,
  output logic sample_hold,
  output logic [9:0] ladder_tap,
  output logic reference_enable,
  input wire logic cmp_in
);
  typedef enum logic [2:0] {
    SAC_IDLE = 3'b001,
    SAC_SAMPLE = 3'b010,
    SAC_CONVERT = 3'b100
  } sac_state_t;

  typedef struct packed {
    sac_state_t state;
    logic [7:0] mode;
    logic [7:0] channel;
    logic [7:0] cmp_mode;
    logic [7:0] threshold;
    logic [9:0] approx;
    logic [3:0] bit_idx;
    logic [4:0] slot;
    logic first_unusable;
    logic [15:0] result;
    logic irq;
    logic [15:0] rdata;
    logic wait_cyc;
    logic [2:0] ch_out;
    logic hold_out;
    logic [9:0] tap_out;
    logic ref_out;
  } sac_ctl_t;

  sac_ctl_t st_ff;
  sac_ctl_t nxt_st;
  logic cmp_sync;
  logic slot_end;
  logic restart;
  logic [15:0] slot_len;
  logic [15:0] conv_len;
  logic [9:0] final_val;
  logic accept;
  logic conv_end;

  sac_sync2 u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .din(cmp_in),
    .dout(cmp_sync)
  );

  sac_slot_timer u_timer (
    .clock(clock),
    .rst_n(rst_n),
    .restart(restart),
    .slot_len(slot_len),
    .slot_end(slot_end)
  );

  // The incoming mode sets the length, so a restarting write runs at its own time code.
  always_comb begin
    case (nxt_st.mode[SAC_MODE_TIME_LSB +: 3])
      3'h0: conv_len = SAC_T288;
      3'h1: conv_len = SAC_T240;
      3'h2: conv_len = SAC_T192;
      3'h4: conv_len = SAC_T144;
      3'h5: conv_len = SAC_T120;
      3'h6: conv_len = SAC_T96;
      default: conv_len = SAC_T96;
    endcase
  end

  // Prohibited codes fall back to the shortest time rather than locking up.
  assign slot_len = conv_len / SAC_SLOTS;

  // Final bit decision folded in so the latched value matches the last trial.
  always_comb begin
    final_val = st_ff.approx;
    final_val[0] = cmp_sync;
  end

  // Last decision slot of a conversion; the checks below key on it.
  assign conv_end = (st_ff.state == SAC_CONVERT) && slot_end && (st_ff.bit_idx == 4'h0);

  always_comb begin
    if (!st_ff.cmp_mode[SAC_CMP_ENABLE_BIT]) begin
      accept = 1'b1;
    end else if (!st_ff.cmp_mode[SAC_CMP_POLARITY_BIT]) begin
      accept = (final_val[9:2] >= st_ff.threshold);
    end else begin
      accept = (final_val[9:2] < st_ff.threshold);
    end
  end

  always_comb begin
    nxt_st = st_ff;
    restart = 1'b0;
    nxt_st.irq = 1'b0;
    nxt_st.wait_cyc = 1'b0;
    // Sequencing.
    case (st_ff.state)
      SAC_IDLE: begin
        if (st_ff.mode[SAC_MODE_RUN_BIT]) begin
          nxt_st.state = SAC_SAMPLE;
          nxt_st.slot = 5'h00;
          nxt_st.first_unusable = !st_ff.mode[SAC_MODE_REF_BIT];
          restart = 1'b1;
        end
      end
      SAC_SAMPLE: begin
        if (slot_end) begin
          nxt_st.slot = st_ff.slot + 5'h01;
          if (st_ff.slot == 5'(SAC_SAMPLE_SLOTS - 16'h0001)) begin
            nxt_st.state = SAC_CONVERT;
            nxt_st.approx = 10'h200;
            nxt_st.bit_idx = 4'h9;
          end
        end
      end
      SAC_CONVERT: begin
        if (slot_end) begin
          if (st_ff.bit_idx == 4'h0) begin
            nxt_st.result = {final_val, 6'h00};
            nxt_st.irq = accept && !st_ff.first_unusable;
            nxt_st.first_unusable = 1'b0;
            nxt_st.state = SAC_SAMPLE;
            nxt_st.slot = 5'h00;
          end else begin
            nxt_st.approx[st_ff.bit_idx] = cmp_sync;
            nxt_st.approx[st_ff.bit_idx - 4'h1] = 1'b1;
            nxt_st.bit_idx = st_ff.bit_idx - 4'h1;
          end
        end
      end
      default: nxt_st.state = SAC_IDLE;
    endcase
    // Control register writes; they take priority and restart a running sequence, or stop it when the run bit is clear.
    if (reg_wr) begin
      nxt_st.wait_cyc = 1'b1;
      case (reg_addr)
        SAC_ADDR_MODE: nxt_st.mode = reg_wdata & SAC_MODE_MASK;
        SAC_ADDR_CHANNEL: nxt_st.channel = reg_wdata & SAC_CHANNEL_MASK;
        SAC_ADDR_CMP_MODE: nxt_st.cmp_mode = reg_wdata & SAC_CMP_MASK;
        SAC_ADDR_THRESHOLD: nxt_st.threshold = reg_wdata;
        default: nxt_st.wait_cyc = 1'b0;
      endcase
      if (nxt_st.wait_cyc && (st_ff.state != SAC_IDLE || restart)) begin
        nxt_st.irq = 1'b0;
        if (nxt_st.mode[SAC_MODE_RUN_BIT]) begin
          nxt_st.state = SAC_SAMPLE;
          nxt_st.slot = 5'h00;
          restart = 1'b1;
        end else begin
          nxt_st.state = SAC_IDLE;
        end
      end
    end
    // Register reads.
    nxt_st.rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        SAC_ADDR_RESULT_LO: begin
          nxt_st.rdata = reg_rd16 ? st_ff.result : {8'h00, st_ff.result[7:0]};
          nxt_st.wait_cyc = 1'b1;
        end
        SAC_ADDR_RESULT_HI: begin
          nxt_st.rdata = {8'h00, st_ff.result[15:8]};
          nxt_st.wait_cyc = 1'b1;
        end
        SAC_ADDR_MODE: nxt_st.rdata = {8'h00, st_ff.mode};
        SAC_ADDR_CHANNEL: nxt_st.rdata = {8'h00, st_ff.channel};
        SAC_ADDR_CMP_MODE: nxt_st.rdata = {8'h00, st_ff.cmp_mode};
        SAC_ADDR_THRESHOLD: nxt_st.rdata = {8'h00, st_ff.threshold};
        default: nxt_st.rdata = 16'h0000;
      endcase
    end
    // Front-end outputs.
    nxt_st.ch_out = nxt_st.channel[2:0];
    nxt_st.hold_out = (nxt_st.state == SAC_CONVERT);
    nxt_st.tap_out = nxt_st.approx;
    nxt_st.ref_out = nxt_st.mode[SAC_MODE_REF_BIT];
  end

  assign reg_rdata = st_ff.rdata;
  assign reg_wait = st_ff.wait_cyc;
  assign conversion_done_irq = st_ff.irq;
  assign channel_sel = st_ff.ch_out;
  assign sample_hold = st_ff.hold_out;
  assign ladder_tap = st_ff.tap_out;
  assign reference_enable = st_ff.ref_out;

  // The result is not cleared by reset; it only holds a value after a conversion.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_ff.state <= SAC_IDLE;
      st_ff.mode <= SAC_RESET_BYTE;
      st_ff.channel <= SAC_RESET_BYTE;
      st_ff.cmp_mode <= SAC_RESET_BYTE;
      st_ff.threshold <= SAC_RESET_BYTE;
      st_ff.approx <= 10'h000;
      st_ff.bit_idx <= 4'h0;
      st_ff.slot <= 5'h00;
      st_ff.first_unusable <= 1'b0;
      st_ff.irq <= 1'b0;
      st_ff.rdata <= 16'h0000;
      st_ff.wait_cyc <= 1'b0;
      st_ff.ch_out <= 3'h0;
      st_ff.hold_out <= 1'b0;
      st_ff.tap_out <= 10'h000;
      st_ff.ref_out <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
    if (rst_n) begin
      st_ff.result <= nxt_st.result;
    end
  end

  result_low_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
    conv_end |=> st_ff.result[5:0] == 6'h00)
    else $error("Result low bits not zero.");
  first_withheld_a: assert property (@(posedge clock) disable iff (!rst_n)
    conv_end && st_ff.first_unusable |=> !conversion_done_irq)
    else $error("Interrupt raised for an unusable first result.");
  plain_irq_a: assert property (@(posedge clock) disable iff (!rst_n)
    conv_end && !st_ff.cmp_mode[SAC_CMP_ENABLE_BIT] && !st_ff.first_unusable && !reg_wr
    |=> conversion_done_irq)
    else $error("Plain conversion ended without interrupt.");
  repeat_restarts_a: assert property (@(posedge clock) disable iff (!rst_n)
    conv_end && st_ff.mode[SAC_MODE_RUN_BIT] && !reg_wr
    |=> st_ff.state == SAC_SAMPLE && st_ff.slot == 5'h00)
    else $error("Conversion did not repeat.");
  high_byte_read_a: assert property (@(posedge clock) disable iff (!rst_n)
    reg_rd && reg_addr == SAC_ADDR_RESULT_HI
    |=> reg_wait && reg_rdata == {8'h00, $past(st_ff.result[15:8])})
    else $error("High result byte read wrong.");
  stop_no_irq_a: assert property (@(posedge clock) disable iff (!rst_n)
    reg_wr && reg_addr == SAC_ADDR_MODE && st_ff.state != SAC_IDLE |=> !conversion_done_irq)
    else $error("Interrupt raised for an aborted conversion.");
  reset_clears_a: assert property (@(posedge clock)
    !rst_n |=> st_ff.channel == 8'h00 && st_ff.cmp_mode == 8'h00 && st_ff.threshold == 8'h00)
    else $error("Control registers not cleared by reset.");
  channel_follows_a: assert property (@(posedge clock) disable iff (!rst_n)
    channel_sel == st_ff.channel[2:0])
    else $error("Channel output differs from register.");
  start_msb_set_a: assert property (@(posedge clock) disable iff (!rst_n)
    st_ff.state == SAC_SAMPLE ##1 st_ff.state == SAC_CONVERT |-> st_ff.approx == 10'h200)
    else $error("Approximation does not start at half scale.");
  irq_compare_a: assert property (@(posedge clock) disable iff (!rst_n)
    conversion_done_irq && st_ff.cmp_mode[SAC_CMP_ENABLE_BIT] && !$past(reg_wr)
    |-> (st_ff.cmp_mode[SAC_CMP_POLARITY_BIT] ? st_ff.result[15:8] < st_ff.threshold
                                             : st_ff.result[15:8] >= st_ff.threshold))
    else $error("Interrupt raised against threshold condition.");
  irq_pulse_a: assert property (@(posedge clock) disable iff (!rst_n)
    conversion_done_irq |=> !conversion_done_irq)
    else $error("Interrupt longer than one cycle.");
  stop_at_once_a: assert property (@(posedge clock) disable iff (!rst_n)
    reg_wr && reg_addr == SAC_ADDR_MODE && !reg_wdata[SAC_MODE_RUN_BIT]
    |=> st_ff.state == SAC_IDLE && !sample_hold)
    else $error("Conversion did not stop on run clear.");
  write_restarts_a: assert property (@(posedge clock) disable iff (!rst_n)
    reg_wr && reg_addr == SAC_ADDR_THRESHOLD && st_ff.mode[SAC_MODE_RUN_BIT]
    |=> st_ff.state == SAC_SAMPLE && st_ff.slot == 5'h00)
    else $error("Control write did not restart conversion.");
  wait_on_write_a: assert property (@(posedge clock) disable iff (!rst_n)
    reg_wr && reg_addr == SAC_ADDR_CHANNEL |=> reg_wait)
    else $error("No wait cycle on control write.");
  hold_in_convert_a: assert property (@(posedge clock) disable iff (!rst_n)
    st_ff.state == SAC_CONVERT |=> sample_hold || st_ff.state != SAC_CONVERT)
    else $error("Hold not asserted while converting.");

  cov_irq_c: cover property (@(posedge clock) disable iff (!rst_n) conversion_done_irq);
  cov_cmp_c: cover property (@(posedge clock) disable iff (!rst_n)
    conversion_done_irq && st_ff.cmp_mode[SAC_CMP_ENABLE_BIT]);
  cov_abort_c: cover property (@(posedge clock) disable iff (!rst_n)
    reg_wr && st_ff.state == SAC_CONVERT);
  cov_stop_c: cover property (@(posedge clock) disable iff (!rst_n)
    reg_wr && reg_addr == SAC_ADDR_MODE && !reg_wdata[SAC_MODE_RUN_BIT] && st_ff.state != SAC_IDLE);
  cov_withheld_c: cover property (@(posedge clock) disable iff (!rst_n)
    conv_end && st_ff.first_unusable);
endmodule
`default_nettype wire

// ### verif/sac_afe_model.sv
/*
  Behavioural analog front end: eight input levels, a sample-hold and a comparator.
  Assumes the controller drives channel, hold and tap outputs and reads cmp_in.
*/
`timescale 1ns/1ps
`default_nettype none
module sac_afe_model (
  // Clock
  input wire logic clock,
  // Controller side
  input wire logic [2:0] channel_sel,
  input wire logic sample_hold,
  input wire logic [9:0] ladder_tap,
  output logic cmp_in,
  // Input levels, ten bits per channel
  input wire logic [79:0] levels
);
  logic [9:0] held = 10'h000;
  logic toggle = 1'b0;
  // While sampling the comparator says nothing useful, so it keeps moving.
  always @(posedge clock) begin
    toggle <= ~toggle;
    if (!sample_hold) begin
      held <= levels[channel_sel * 10 +: 10];
    end
  end
  assign cmp_in = sample_hold ? (held >= ladder_tap) : toggle;
endmodule
`default_nettype wire

// ### verif/tb.sv
/*
  Self-checking bench for the converter controller.
  Assumes the front end model and a 250 MHz clock; times are counted in clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sac_pkg::*;
  localparam int LIMIT = 100000;
  localparam int LEN96 = 96 * SAC_SCALE;
  localparam int SLOT = LEN96 / 22;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic reg_rd16 = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [15:0] reg_rdata;
  logic reg_wait;
  logic irq;
  logic sample_hold;
  logic reference_enable;
  logic cmp_in;
  logic [2:0] channel_sel;
  logic [9:0] ladder_tap;
  logic [79:0] levels = 80'h0;
  int error_cnt = 0;
  int total_checks = 0;
  int cycles = 0;

  sac_adc_ctrl i_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rd16(reg_rd16), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_wait(reg_wait), .conversion_done_irq(irq), .channel_sel(channel_sel),
    .sample_hold(sample_hold), .ladder_tap(ladder_tap), .reference_enable(reference_enable),
    .cmp_in(cmp_in));
  sac_afe_model i_afe (.clock(clock), .channel_sel(channel_sel), .sample_hold(sample_hold),
    .ladder_tap(ladder_tap), .cmp_in(cmp_in), .levels(levels));

  always #2 clock = ~clock;

  task automatic complete_run();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // A hang is cut off well past the expected run length.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      error_cnt = error_cnt + 1;
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clock);
    #1;
    reg_wr = 1'b0;
    chk("write wait", {15'h0000, reg_wait}, 16'h0001);
  endtask

  task automatic rd(input logic [15:0] a, input logic w, output logic [15:0] q);
    @(posedge clock);
    #1;
    reg_addr = a;
    reg_rd16 = w;
    reg_rd = 1'b1;
    @(posedge clock);
    #1;
    reg_rd = 1'b0;
    reg_rd16 = 1'b0;
    q = reg_rdata;
    chk("read wait", {15'h0000, reg_wait}, {15'h0000, a[15:1] == 15'h7F84});
  endtask

  task automatic wait_irq(input int max, output int n);
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n = n + 1;
    end while (irq !== 1'b1 && n < max);
  endtask

  task automatic t_reset();
    logic [15:0] q;
    for (int a = 16'hFF28; a <= 16'hFF2C; a++) begin
      rd(16'(a), 1'b0, q);
      chk("reset value", q, 16'h0000);
    end
    chk("reset outputs", {10'h000, channel_sel, reference_enable, sample_hold, irq}, 16'h0000);
  endtask

  task automatic t_channels();
    logic [15:0] q;
    int n;
    levels = {10'h2D9, 10'h3FF, 10'h1A3, 10'h155, 10'h0AA, 10'h201, 10'h000, 10'h12C};
    wr(SAC_ADDR_MODE, 8'h31);
    // The reference needs time to settle before the first usable result.
    repeat (3500) @(posedge clock);
    wr(SAC_ADDR_MODE, 8'hB1);
    chk("reference out", {15'h0000, reference_enable}, 16'h0001);
    for (int c = 0; c < 8; c++) begin
      wr(SAC_ADDR_CHANNEL, 8'(c));
      chk("channel", {13'h0000, channel_sel}, 16'(c));
      wait_irq(LEN96 + 100, n);
      chk("done", {15'h0000, irq}, 16'h0001);
      rd(SAC_ADDR_RESULT_LO, 1'b1, q);
      chk("result", q, {levels[c * 10 +: 10], 6'h00});
    end
    wait_irq(LEN96 + 100, n);
    chk("repeat", {15'h0000, irq}, 16'h0001);
    rd(SAC_ADDR_RESULT_HI, 1'b0, q);
    chk("high byte", {8'h00, q[7:0]}, 16'h00B6);
    rd(SAC_ADDR_RESULT_LO, 1'b0, q);
    chk("low byte", {8'h00, q[7:0]}, 16'h0040);
  endtask

  task automatic t_compare();
    logic [7:0] mode_v [4] = '{8'h80, 8'h80, 8'hC0, 8'hC0};
    logic [7:0] thr_v [4] = '{8'h68, 8'h69, 8'h69, 8'h68};
    logic exp_v [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic [15:0] q;
    int n;
    wr(SAC_ADDR_CHANNEL, 8'h05);
    for (int i = 0; i < 4; i++) begin
      wr(SAC_ADDR_THRESHOLD, thr_v[i]);
      wr(SAC_ADDR_CMP_MODE, mode_v[i]);
      wait_irq(LEN96 + 100, n);
      chk("compare irq", {15'h0000, irq}, {15'h0000, exp_v[i]});
    end
    rd(SAC_ADDR_RESULT_LO, 1'b1, q);
    chk("withheld result", q, {10'h1A3, 6'h00});
    wr(SAC_ADDR_CMP_MODE, 8'h00);
  endtask

  task automatic t_times();
    int per [6] = '{288, 240, 192, 144, 120, 96};
    logic [2:0] code [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    int n;
    for (int i = 0; i < 6; i++) begin
      wr(SAC_ADDR_MODE, {2'b10, code[i], 3'b001});
      wait_irq(per[i] * SAC_SCALE + 40, n);
      chk("conv time", {15'h0000, irq === 1'b1 && n > per[i] * SAC_SCALE - 30}, 16'h0001);
    end
  endtask

  task automatic t_stop();
    int n;
    wr(SAC_ADDR_MODE, 8'hB1);
    n = 0;
    while (sample_hold !== 1'b1 && n < 2000) begin
      @(posedge clock);
      #1;
      n = n + 1;
    end
    chk("sample slots", 16'((n + SLOT / 2) / SLOT), 16'h000C);
    chk("first trial", {6'h00, ladder_tap}, 16'h0200);
    repeat (300) @(posedge clock);
    wr(SAC_ADDR_MODE, 8'h31);
    wait_irq(LEN96 + 100, n);
    chk("stopped irq", {15'h0000, irq}, 16'h0000);
    chk("stopped hold", {15'h0000, sample_hold}, 16'h0000);
  endtask

  task automatic t_noref();
    int n;
    // Deliberately started without the reference; the first result is unusable.
    wr(SAC_ADDR_MODE, 8'hB0);
    wait_irq(3 * LEN96, n);
    chk("first withheld", {15'h0000, irq === 1'b1 && n > LEN96 + LEN96 / 2}, 16'h0001);
    wr(SAC_ADDR_MODE, 8'h00);
  endtask

  initial begin
    repeat (3) @(posedge clock);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_channels();
    t_compare();
    t_times();
    t_stop();
    t_noref();
    complete_run();
  end
endmodule
`default_nettype wire
